// [pkg/rfsss_pkg.sv]
// package with register map, selector codes and signal bundles of the serial signal switch
package rfsss_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] RFSSS_OFS_RECEIVE_CONTROL_SECOND = 8'h00;
  localparam logic [7:0] RFSSS_OFS_TRANSMIT_CONTROL = 8'h04;
  localparam logic [7:0] RFSSS_OFS_SERIAL_OUT_SELECT = 8'h08;
  localparam logic [7:0] RFSSS_OFS_DIGITAL_TEST_SELECT = 8'h0C;
  localparam logic [7:0] RFSSS_OFS_SWITCH_STATUS = 8'h10;

  // field positions inside the registers
  localparam int RFSSS_POS_DEC_SEL = 0;
  localparam int RFSSS_POS_MOD_SEL = 0;
  localparam int RFSSS_POS_OUT_SEL = 0;
  localparam int RFSSS_POS_OVERRIDE = 0;

  // decoder input selector codes
  typedef enum logic [1:0] {
    RFSSS_DEC_ZERO = 2'h0,
    RFSSS_DEC_ANALOG = 2'h1,
    RFSSS_DEC_PIN_SUBC = 2'h2,
    RFSSS_DEC_PIN_PLAIN = 2'h3
  } rfsss_dec_sel_type;

  // modulator input selector codes
  typedef enum logic [1:0] {
    RFSSS_MOD_ZERO = 2'h0,
    RFSSS_MOD_ONE = 2'h1,
    RFSSS_MOD_ENCODER = 2'h2,
    RFSSS_MOD_PIN_MILLER = 2'h3
  } rfsss_mod_sel_type;

  // serial output selector codes
  typedef enum logic [2:0] {
    RFSSS_OUT_LOW = 3'h0,
    RFSSS_OUT_HIGH = 3'h1,
    RFSSS_OUT_ENVELOPE = 3'h2,
    RFSSS_OUT_TX_RAW = 3'h3,
    RFSSS_OUT_RX_REGEN = 3'h4,
    RFSSS_OUT_SUBC_DEMOD = 3'h5,
    RFSSS_OUT_RSVD6 = 3'h6,
    RFSSS_OUT_RSVD7 = 3'h7
  } rfsss_out_sel_type;

  // values after reset
  localparam rfsss_dec_sel_type RFSSS_RST_DEC_SEL = RFSSS_DEC_ANALOG;
  localparam rfsss_mod_sel_type RFSSS_RST_MOD_SEL = RFSSS_MOD_ENCODER;
  localparam rfsss_out_sel_type RFSSS_RST_OUT_SEL = RFSSS_OUT_LOW;
  localparam logic RFSSS_RST_OVERRIDE = 1'h0;

  // subcarrier frequency and only supported rate on the pin paths
  localparam int RFSSS_SUBCARRIER_HZ = 847500;
  localparam int RFSSS_PIN_PATH_BAUD = 106000;

  // signals arriving from the core coder, decoder and analog front end
  typedef struct packed {
    logic analog_rx;
    logic enc_envelope;
    logic tx_raw;
    logic rx_regen;
    logic subc_demod;
    logic test_signal;
  } rfsss_core_in_type;

  // signals handed to the decoder and modulator
  typedef struct packed {
    logic decoder_in;
    logic decoder_expect_subcarrier;
    logic decoder_from_pin;
    logic modulator_in;
  } rfsss_core_out_type;

endpackage

// [rtl/rfsss_sync.sv]
// two flip-flop synchroniser for the serial input pin
`timescale 1ns/1ps
module rfsss_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;

  // first stage is read only by the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// [rtl/rfsss_switch.sv]
// serial signal switch: apb control registers and the three signal selectors
//
// Behaviour
// - decoder code 00 feeds constant zero
// - decoder code 01 takes analog receiver; reset default
// - decoder code 10 takes pin, subcarrier Manchester
// - decoder code 11 takes pin, plain Manchester
// - modulator result drives both antenna pins
// - modulator code 00 holds input at zero
// - modulator code 01 holds input at one
// - modulator code 10 takes encoder envelope; default
// - modulator code 11 takes pin Miller signal
// - output code 000 low, 001 high
// - output code 010 drives encoder envelope
// - output code 011 drives raw transmit bitstream
// - output code 100 drives regenerated receiver output
// - output code 101 drives subcarrier demodulator output
// - output selector acts only without test override
// - pin Manchester routing meant only for 106 kBd; rate not checked
`timescale 1ns/1ps
module rfsss_switch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rfsss_pkg::rfsss_core_in_type core_in,
  input wire logic serial_in_pin,
  output rfsss_pkg::rfsss_core_out_type core_out,
  output logic antenna_drive_a,
  output logic antenna_drive_b,
  output logic serial_out_pin
);
  import rfsss_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // control registers and synchronised pin

  rfsss_dec_sel_type dec_sel_q;
  rfsss_mod_sel_type mod_sel_q;
  rfsss_out_sel_type out_sel_q;
  logic override_q;
  logic [31:0] prdata_q;
  rfsss_core_out_type core_out_q;
  rfsss_core_out_type core_out_d;
  logic serial_out_q;
  logic serial_out_d;
  logic modulated_q;
  logic pin_sync;

  // pin comes from another device, so it is synchronised first
  rfsss_sync u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(serial_in_pin),
    .sync_out(pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  // address decode for each register
  wire hit_rx = (paddr == RFSSS_OFS_RECEIVE_CONTROL_SECOND);
  wire hit_tx = (paddr == RFSSS_OFS_TRANSMIT_CONTROL);
  wire hit_out = (paddr == RFSSS_OFS_SERIAL_OUT_SELECT);
  wire hit_test = (paddr == RFSSS_OFS_DIGITAL_TEST_SELECT);
  wire hit_stat = (paddr == RFSSS_OFS_SWITCH_STATUS);
  wire hit_any = hit_rx | hit_tx | hit_out | hit_test | hit_stat;

  // phase strobes; status register is read only
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_ok = access_ph & pwrite & hit_any & ~hit_stat;
  wire wr_rx = wr_ok & hit_rx;
  wire wr_tx = wr_ok & hit_tx;
  wire wr_out = wr_ok & hit_out;
  wire wr_test = wr_ok & hit_test;

  // zero wait states; unmapped address or write to status flags an error
  assign pready = 1'h1;
  assign pslverr = access_ph & (~hit_any | (pwrite & hit_stat));

  // read data, assembled for the register addressed in the setup phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_rx) begin
      rd_mux[RFSSS_POS_DEC_SEL +: 2] = dec_sel_q;
    end
    if (hit_tx) begin
      rd_mux[RFSSS_POS_MOD_SEL +: 2] = mod_sel_q;
    end
    if (hit_out) begin
      rd_mux[RFSSS_POS_OUT_SEL +: 3] = out_sel_q;
    end
    if (hit_test) begin
      rd_mux[RFSSS_POS_OVERRIDE] = override_q;
    end
    if (hit_stat) begin
      rd_mux[3:0] = {core_out_q.decoder_in, modulated_q, serial_out_q, pin_sync};
    end
  end

  // read data register, loaded during setup so it is steady in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup_ph & ~pwrite) begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata = prdata_q;

  // selector registers, written at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_sel_q <= RFSSS_RST_DEC_SEL;
      mod_sel_q <= RFSSS_RST_MOD_SEL;
      out_sel_q <= RFSSS_RST_OUT_SEL;
      override_q <= RFSSS_RST_OVERRIDE;
    end else begin
      if (wr_rx) begin
        dec_sel_q <= rfsss_dec_sel_type'(pwdata[RFSSS_POS_DEC_SEL +: 2]);
      end
      if (wr_tx) begin
        mod_sel_q <= rfsss_mod_sel_type'(pwdata[RFSSS_POS_MOD_SEL +: 2]);
      end
      if (wr_out) begin
        out_sel_q <= rfsss_out_sel_type'(pwdata[RFSSS_POS_OUT_SEL +: 3]);
      end
      if (wr_test) begin
        override_q <= pwdata[RFSSS_POS_OVERRIDE];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // selectors

  // decoder source; pin paths only meant for 106 kBd Manchester
  always_comb begin
    core_out_d = '0;
    unique case (dec_sel_q)
      RFSSS_DEC_ZERO: core_out_d.decoder_in = 1'h0;
      RFSSS_DEC_ANALOG: core_out_d.decoder_in = core_in.analog_rx;
      RFSSS_DEC_PIN_SUBC: begin
        core_out_d.decoder_in = pin_sync;
        core_out_d.decoder_expect_subcarrier = 1'h1;
        core_out_d.decoder_from_pin = 1'h1;
      end
      RFSSS_DEC_PIN_PLAIN: begin
        core_out_d.decoder_in = pin_sync;
        core_out_d.decoder_from_pin = 1'h1;
      end
    endcase
    unique case (mod_sel_q)
      RFSSS_MOD_ZERO: core_out_d.modulator_in = 1'h0;
      RFSSS_MOD_ONE: core_out_d.modulator_in = 1'h1;
      RFSSS_MOD_ENCODER: core_out_d.modulator_in = core_in.enc_envelope;
      RFSSS_MOD_PIN_MILLER: core_out_d.modulator_in = pin_sync;
    endcase
  end

  // serial output source; override hands the pin to the test signal
  always_comb begin
    serial_out_d = 1'h0;
    if (override_q) begin
      serial_out_d = core_in.test_signal;
    end else begin
      unique case (out_sel_q)
        RFSSS_OUT_LOW: serial_out_d = 1'h0;
        RFSSS_OUT_HIGH: serial_out_d = 1'h1;
        RFSSS_OUT_ENVELOPE: serial_out_d = core_in.enc_envelope;
        RFSSS_OUT_TX_RAW: serial_out_d = core_in.tx_raw;
        RFSSS_OUT_RX_REGEN: serial_out_d = core_in.rx_regen;
        RFSSS_OUT_SUBC_DEMOD: serial_out_d = core_in.subc_demod;
        RFSSS_OUT_RSVD6: serial_out_d = 1'h0;
        RFSSS_OUT_RSVD7: serial_out_d = 1'h0;
      endcase
    end
  end

  // output flops: a selector write shows one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_out_q <= '0;
      serial_out_q <= 1'h0;
      modulated_q <= 1'h0;
    end else begin
      core_out_q <= core_out_d;
      serial_out_q <= serial_out_d;
      modulated_q <= core_out_d.modulator_in;
    end
  end

  // one modulated envelope feeds both antenna drivers
  assign core_out = core_out_q;
  assign antenna_drive_a = modulated_q;
  assign antenna_drive_b = modulated_q;
  assign serial_out_pin = serial_out_q;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_dec_zero;
    (dec_sel_q == RFSSS_DEC_ZERO) |=> !core_out.decoder_in;
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("decoder not zero");

  property p_dec_analog;
    (dec_sel_q == RFSSS_DEC_ANALOG) |=> core_out.decoder_in == $past(core_in.analog_rx);
  endproperty
  a_dec_analog: assert property (p_dec_analog) else $error("decoder not analog");

  property p_dec_subc;
    (dec_sel_q == RFSSS_DEC_PIN_SUBC) |=>
      core_out.decoder_in == $past(pin_sync) && core_out.decoder_expect_subcarrier;
  endproperty
  a_dec_subc: assert property (p_dec_subc) else $error("decoder pin subc wrong");

  property p_dec_plain;
    (dec_sel_q == RFSSS_DEC_PIN_PLAIN) |=>
      core_out.decoder_in == $past(pin_sync) && !core_out.decoder_expect_subcarrier;
  endproperty
  a_dec_plain: assert property (p_dec_plain) else $error("decoder pin plain wrong");

  property p_ant_pair;
    antenna_drive_a == antenna_drive_b && antenna_drive_a == core_out.modulator_in;
  endproperty
  a_ant_pair: assert property (p_ant_pair) else $error("antenna drives differ");

  property p_mod_const;
    (mod_sel_q == RFSSS_MOD_ZERO) |=> !antenna_drive_a && !antenna_drive_b;
  endproperty
  a_mod_const: assert property (p_mod_const) else $error("carrier not off");

  property p_mod_one;
    (mod_sel_q == RFSSS_MOD_ONE) |=> core_out.modulator_in;
  endproperty
  a_mod_one: assert property (p_mod_one) else $error("carrier not on");

  property p_mod_enc;
    (mod_sel_q == RFSSS_MOD_ENCODER) |=> core_out.modulator_in == $past(core_in.enc_envelope);
  endproperty
  a_mod_enc: assert property (p_mod_enc) else $error("modulator not encoder");

  property p_mod_pin;
    (mod_sel_q == RFSSS_MOD_PIN_MILLER) |=> core_out.modulator_in == $past(pin_sync);
  endproperty
  a_mod_pin: assert property (p_mod_pin) else $error("modulator not pin");

  property p_out_const;
    (!override_q && out_sel_q inside {RFSSS_OUT_LOW, RFSSS_OUT_HIGH}) |=>
      serial_out_pin == $past(out_sel_q[0]);
  endproperty
  a_out_const: assert property (p_out_const) else $error("serial out level wrong");

  property p_out_env;
    (!override_q && out_sel_q == RFSSS_OUT_ENVELOPE) |=>
      serial_out_pin == $past(core_in.enc_envelope);
  endproperty
  a_out_env: assert property (p_out_env) else $error("serial out not envelope");

  property p_out_raw;
    (!override_q && out_sel_q == RFSSS_OUT_TX_RAW) |=> serial_out_pin == $past(core_in.tx_raw);
  endproperty
  a_out_raw: assert property (p_out_raw) else $error("serial out not raw");

  property p_out_regen;
    (!override_q && out_sel_q == RFSSS_OUT_RX_REGEN) |=>
      serial_out_pin == $past(core_in.rx_regen);
  endproperty
  a_out_regen: assert property (p_out_regen) else $error("serial out not regen");

  property p_out_demod;
    (!override_q && out_sel_q == RFSSS_OUT_SUBC_DEMOD) |=>
      serial_out_pin == $past(core_in.subc_demod);
  endproperty
  a_out_demod: assert property (p_out_demod) else $error("serial out not demod");

  property p_override;
    override_q |=> serial_out_pin == $past(core_in.test_signal);
  endproperty
  a_override: assert property (p_override) else $error("override not honoured");

  property p_out_rsvd;
    (!override_q && out_sel_q[2:1] == 2'h3) |=> !serial_out_pin;
  endproperty
  a_out_rsvd: assert property (p_out_rsvd) else $error("reserved code not low");

  property p_write_lat;
    (wr_out && !override_q && pwdata[2:0] == 3'h1) ##1 (!wr_out && !wr_test) |=> serial_out_pin;
  endproperty
  a_write_lat: assert property (p_write_lat) else $error("write not applied");

  // selectors move only on a register write, never on their own
  property p_sel_steady;
    (!wr_rx && !wr_tx && !wr_out) |=>
      $stable(dec_sel_q) && $stable(mod_sel_q) && $stable(out_sel_q);
  endproperty
  a_sel_steady: assert property (p_sel_steady) else $error("selector moved");

  // internal decoder sources leave the pin mode flags low
  property p_dec_local;
    (dec_sel_q inside {RFSSS_DEC_ZERO, RFSSS_DEC_ANALOG}) |=>
      !core_out.decoder_from_pin && !core_out.decoder_expect_subcarrier;
  endproperty
  a_dec_local: assert property (p_dec_local) else $error("decoder pin flags set");

  // pin reaches the decoder after two sync stages and the output flop
  property p_pin_lat;
    (dec_sel_q == RFSSS_DEC_PIN_PLAIN) |=> core_out.decoder_in == $past(serial_in_pin, 3);
  endproperty
  a_pin_lat: assert property (p_pin_lat) else $error("pin latency wrong");

  // continuous carrier shows on both antenna pins
  property p_mod_both;
    (mod_sel_q == RFSSS_MOD_ONE) |=> antenna_drive_a && antenna_drive_b;
  endproperty
  a_mod_both: assert property (p_mod_both) else $error("carrier missing on a pin");

  // main scenarios
  c_analog_half: cover property (mod_sel_q == RFSSS_MOD_PIN_MILLER &&
    out_sel_q == RFSSS_OUT_RX_REGEN);
  c_digital_half: cover property (dec_sel_q == RFSSS_DEC_PIN_SUBC &&
    out_sel_q == RFSSS_OUT_ENVELOPE);
  c_override: cover property (override_q && core_in.test_signal);
  c_bad_addr: cover property (pslverr);
  c_carrier_off: cover property (mod_sel_q == RFSSS_MOD_ZERO && !antenna_drive_a);

endmodule

// [verification/rfsss_far_half.sv]
// far-side reader half model that drives the serial input pin
`timescale 1ns/1ps
module rfsss_far_half (
  input wire logic pclk,
  input wire logic frame_on,
  input wire logic bit_val,
  output logic serial_in_pin
);
  // within a frame the pin carries the bit; released, it toggles so no stale level survives
  // frames here follow bit_val on every rising pclk edge; no bit rate is imposed on them
  initial serial_in_pin = 1'h0;
  always @(posedge pclk) begin
    serial_in_pin <= frame_on ? bit_val : ~serial_in_pin;
  end
endmodule

// [verification/rf_serial_signal_switch_bench.sv]
// self-checking bench for the serial signal switch
`timescale 1ns/1ps
module rf_serial_signal_switch_bench;
  import rfsss_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  rfsss_core_in_type core_in;
  rfsss_core_out_type core_out;
  logic antenna_drive_a, antenna_drive_b, serial_out_pin, serial_in_pin, frame_on, bit_val;
  logic ex_dec, ex_mod, ex_out;
  logic [1:0] cm;
  int miscompares, checked;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // design and far-side model
  rfsss_switch i_rfsss_switch (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_in(core_in), .serial_in_pin(serial_in_pin),
    .core_out(core_out), .antenna_drive_a(antenna_drive_a),
    .antenna_drive_b(antenna_drive_b), .serial_out_pin(serial_out_pin));
  rfsss_far_half i_rfsss_far_half (.pclk(pclk), .frame_on(frame_on), .bit_val(bit_val),
    .serial_in_pin(serial_in_pin));

  // 10 MHz clock
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one apb transfer: setup, access held until pready is seen high
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // core signals and pin bit derived from a 2-bit pattern; each source is v[0], v[1], an inversion or their parity
  task automatic stim(input logic [1:0] v);
    @(posedge pclk);
    core_in <= '{analog_rx: v[0], enc_envelope: v[0], tx_raw: v[1], rx_regen: ~v[0],
      subc_demod: ~v[1], test_signal: ^v};
    bit_val <= ~v[0];
  endtask

  // one edge after the write edge, then let it settle
  task automatic settle();
    @(posedge pclk);
    #1;
  endtask

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    core_in = '0;
    frame_on = 1'h1;
    bit_val = 1'h0;
    miscompares = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    // reset values and refused accesses
    xfer(RFSSS_OFS_RECEIVE_CONTROL_SECOND, 1'h0, 32'h0);
    chk("decoder_input_select", 32'h1, rd_q);
    xfer(RFSSS_OFS_TRANSMIT_CONTROL, 1'h0, 32'h0);
    chk("modulator_input_select", 32'h2, rd_q);
    xfer(RFSSS_OFS_SERIAL_OUT_SELECT, 1'h0, 32'h0);
    chk("serial_out_select", 32'h0, rd_q);
    xfer(RFSSS_OFS_DIGITAL_TEST_SELECT, 1'h0, 32'h0);
    chk("test_output_override", 32'h0, rd_q);
    xfer(8'h14, 1'h0, 32'h0);
    chk("unmapped_read", 32'h0, rd_q);
    chk("unmapped_err", 32'h1, {31'h0, err_q});
    xfer(RFSSS_OFS_SWITCH_STATUS, 1'h1, 32'hF);
    chk("status_write_err", 32'h1, {31'h0, err_q});
    // every code of the three selectors against every source pattern
    for (int c = 0; c < 8; c++) begin
      for (int v = 0; v < 4; v++) begin
        stim(v[1:0]);
        if (c < 4) begin
          xfer(RFSSS_OFS_RECEIVE_CONTROL_SECOND, 1'h1, 32'(c));
          xfer(RFSSS_OFS_TRANSMIT_CONTROL, 1'h1, 32'(c));
        end
        xfer(RFSSS_OFS_SERIAL_OUT_SELECT, 1'h1, 32'(c));
        settle();
        cm = (c < 4) ? c[1:0] : 2'h3;
        ex_dec = (cm == 2'h0) ? 1'h0 : (cm == 2'h1) ? v[0] : ~v[0];
        ex_mod = (cm == 2'h0) ? 1'h0 : (cm == 2'h1) ? 1'h1 : (cm == 2'h2) ? v[0] : ~v[0];
        case (c)
          0: ex_out = 1'h0;
          1: ex_out = 1'h1;
          2: ex_out = v[0];
          3: ex_out = v[1];
          4: ex_out = ~v[0];
          5: ex_out = ~v[1];
          default: ex_out = 1'h0;
        endcase
        chk("decoder_in", ex_dec, core_out.decoder_in);
        chk("decoder_mode", {cm == 2'h2, cm[1]}, {core_out.decoder_expect_subcarrier,
          core_out.decoder_from_pin});
        chk("modulator_in", ex_mod, core_out.modulator_in);
        chk("antenna_drive", {2{ex_mod}}, {antenna_drive_a, antenna_drive_b});
        chk("serial_out_pin", ex_out, serial_out_pin);
      end
    end
    // override takes the pin away from the selector, reserved code then low again
    stim(2'h1);
    xfer(RFSSS_OFS_DIGITAL_TEST_SELECT, 1'h1, 32'h1);
    settle();
    chk("override_on", 32'h1, serial_out_pin);
    xfer(RFSSS_OFS_DIGITAL_TEST_SELECT, 1'h1, 32'h0);
    settle();
    chk("override_off", 32'h0, serial_out_pin);
    // analog half of an active antenna
    stim(2'h2);
    xfer(RFSSS_OFS_TRANSMIT_CONTROL, 1'h1, 32'h3);
    xfer(RFSSS_OFS_SERIAL_OUT_SELECT, 1'h1, 32'h4);
    settle();
    chk("analog_half", 32'h3, {antenna_drive_a, serial_out_pin});
    // digital half, passive path parked meanwhile
    xfer(RFSSS_OFS_TRANSMIT_CONTROL, 1'h1, 32'h0);
    xfer(RFSSS_OFS_SERIAL_OUT_SELECT, 1'h1, 32'h2);
    xfer(RFSSS_OFS_RECEIVE_CONTROL_SECOND, 1'h1, 32'h2);
    settle();
    chk("digital_half", 32'h2, {core_out.decoder_in, serial_out_pin});
    chk("passive_off", 32'h0, {antenna_drive_a, antenna_drive_b});
    // status word: decoder_in, antenna drive, serial out, synchronised pin
    xfer(RFSSS_OFS_SWITCH_STATUS, 1'h0, 32'h0);
    chk("switch_status", 32'h9, rd_q);
    chk("status_read_err", 32'h0, {31'h0, err_q});
    xfer(RFSSS_OFS_SERIAL_OUT_SELECT, 1'h0, 32'h0);
    chk("serial_out_select_back", 32'h2, rd_q);
    summarize();
  end
endmodule
